/* File: hw/tbac_pkg.sv */
// Package: constants, types and decode functions of the 16-bit timer with byte access
`default_nettype none
package tbac_pkg;

  // I/O locations of the timer's byte registers
  localparam logic [3:0] ADDR_CTRL_FIRST   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND  = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOWER  = 4'h2;
  localparam logic [3:0] ADDR_COUNT_UPPER  = 4'h3;
  localparam logic [3:0] ADDR_MATCH_A_LOW  = 4'h4;
  localparam logic [3:0] ADDR_MATCH_A_HIGH = 4'h5;
  localparam logic [3:0] ADDR_MATCH_B_LOW  = 4'h6;
  localparam logic [3:0] ADDR_MATCH_B_HIGH = 4'h7;
  localparam logic [3:0] ADDR_CAPT_LOW     = 4'h8;
  localparam logic [3:0] ADDR_CAPT_HIGH    = 4'h9;
  localparam logic [3:0] ADDR_FLAGS        = 4'ha;

  // Field positions
  localparam int unsigned CF_MODE_LSB = 0;  // Mode bits 1:0 in control_first
  localparam int unsigned CS_SEL_LSB  = 0;  // Clock select 2:0 in control_second
  localparam int unsigned CS_MODE_LSB = 3;  // Mode bits 3:2 at bits 4:3 of control_second
  localparam int unsigned FLAG_OVF    = 0;  // Overflow flag in the flag register

  // Reset and fixed values
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] FLOOR_VAL  = 16'h0000;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  localparam logic [15:0] MAX_VAL    = 16'hffff;

  // Clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler terminal masks
  localparam logic [9:0] PRE_MASK8    = 10'h007;
  localparam logic [9:0] PRE_MASK64   = 10'h03f;
  localparam logic [9:0] PRE_MASK256  = 10'h0ff;
  localparam logic [9:0] PRE_MASK1024 = 10'h3ff;
  localparam logic [9:0] PRE_STEP     = 10'h001;

  // CPU byte request
  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tbac_io_req_t;

  // Counting sequence class
  typedef enum logic [3:0] {
    SEQ_NORMAL = 4'b0001,
    SEQ_CLEAR  = 4'b0010,
    SEQ_FAST   = 4'b0100,
    SEQ_PHASE  = 4'b1000
  } tbac_seq_t;

  // Controls of the counter core
  typedef struct packed {
    logic        load;
    logic [15:0] load_value;
    logic        count;
    logic        down;
    logic        clear;
  } tbac_core_ctl_t;

  typedef struct packed {
    logic [15:0] value;
  } tbac_core_state_t;

  typedef struct packed {
    logic [7:0]  staging;
    logic [7:0]  ctrl_first;
    logic [7:0]  ctrl_second;
    logic [15:0] match_a;
    logic [15:0] match_b;
    logic [15:0] capture;
    logic        ovf;
    logic        down;
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;
    logic [9:0]  prescale;
    logic [7:0]  rdata;
  } tbac_state_t;

  localparam tbac_state_t      STATE_RESET = '0;
  localparam tbac_core_state_t CORE_RESET  = '0;

  // Sequence class of a waveform mode
  function automatic tbac_seq_t seq_of(input logic [3:0] mode);
    case (mode)
      4'h0, 4'hd:                   seq_of = SEQ_NORMAL;
      4'h4, 4'hc:                   seq_of = SEQ_CLEAR;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: seq_of = SEQ_FAST;
      default:                      seq_of = SEQ_PHASE;
    endcase
  endfunction : seq_of

  // Sequence ceiling of a waveform mode
  function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] a, input logic [15:0] cap);
    case (mode)
      4'h1, 4'h5:             top_of = TOP_8BIT;
      4'h2, 4'h6:             top_of = TOP_9BIT;
      4'h3, 4'h7:             top_of = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_of = a;
      4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
      default:                top_of = MAX_VAL;
    endcase
  endfunction : top_of

  // Capture register defines the ceiling in this mode
  function automatic logic capture_is_top(input logic [3:0] mode);
    case (mode)
      4'h8, 4'ha, 4'hc, 4'he: capture_is_top = 1'b1;
      default:                capture_is_top = 1'b0;
    endcase
  endfunction : capture_is_top

endpackage : tbac_pkg
`default_nettype wire

/* File: hw/tbac_count_core.sv */
// Counter core: 16-bit up/down counter with load, clear and count controls
`default_nettype none
module tbac_count_core
  import tbac_pkg::*;
(
  input  wire logic           clock,  // System clock
  input  wire logic           rst,    // Asynchronous reset
  input  wire tbac_core_ctl_t ctl,    // Load, clear, count, direction
  output logic [15:0]         value   // Counter value
);

  tbac_core_state_t state;
  tbac_core_state_t next_state;

  // Load has priority over clear, clear over count
  always_comb begin
    next_state = state;
    if (ctl.load) begin
      next_state.value = ctl.load_value;
    end else if (ctl.clear) begin
      next_state.value = FLOOR_VAL;
    end else if (ctl.count) begin
      next_state.value = ctl.down ? state.value - 16'h0001 : state.value + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= CORE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;

endmodule : tbac_count_core
`default_nettype wire

/* File: hw/tbac_timer.sv */
// Main file: 16-bit timer with shared high-byte staging for 8-bit CPU access
`default_nettype none
module tbac_timer
  import tbac_pkg::*;
(
  input  wire logic          CLOCK,          // System clock, 20 MHz
  input  wire logic          RST,            // Asynchronous reset, active high
  input  wire tbac_io_req_t  IO_REQ,         // CPU byte request
  output logic [7:0]         IO_RDATA,       // Read data, one cycle after request
  input  wire logic          EXT_CLK_PIN,    // External timer clock pin
  output logic [15:0]        COUNT_VALUE,    // Counter value
  output logic               TIMER_TICK,     // Timer tick this cycle
  output logic               TOP_REACHED,    // Counter equals ceiling
  output logic               FLOOR_REACHED,  // Counter equals zero
  output logic               OVERFLOW_FLAG   // Overflow flag, interrupt request
);

  tbac_state_t    state;
  tbac_state_t    next_state;
  tbac_core_ctl_t ctl;
  logic [15:0]    value;
  logic [3:0]     mode;
  logic [2:0]     csel;
  tbac_seq_t      seq;
  logic [15:0]    top;
  logic           tick;
  logic           at_top;
  logic           at_floor;
  logic           ovf_event;
  logic           wr_count_low;

  tbac_count_core u_core (
    .clock (CLOCK),
    .rst   (RST),
    .ctl   (ctl),
    .value (value)
  );

  // Mode, ceiling and extreme-value indications
  always_comb begin
    mode     = {state.ctrl_second[CS_MODE_LSB+:2], state.ctrl_first[CF_MODE_LSB+:2]};
    csel     = state.ctrl_second[CS_SEL_LSB+:3];
    seq      = seq_of(mode);
    top      = top_of(mode, state.match_a, state.capture);
    at_top   = (value == top);
    at_floor = (value == FLOOR_VAL);
  end

  // Timer tick from prescaler or synchronised external pin
  always_comb begin
    case (csel)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (state.prescale & PRE_MASK8) == PRE_MASK8;
      CS_DIV64:    tick = (state.prescale & PRE_MASK64) == PRE_MASK64;
      CS_DIV256:   tick = (state.prescale & PRE_MASK256) == PRE_MASK256;
      CS_DIV1024:  tick = state.prescale == PRE_MASK1024;
      CS_EXT_FALL: tick = state.ext_prev && !state.ext_sync;
      CS_EXT_RISE: tick = !state.ext_prev && state.ext_sync;
      default:     tick = 1'b0;
    endcase
  end

  assign wr_count_low = IO_REQ.wr && (IO_REQ.addr == ADDR_COUNT_LOWER);

  // Next state: bus access, counting sequence and overflow
  always_comb begin
    next_state          = state;
    ctl                 = '0;
    ovf_event           = 1'b0;
    next_state.ext_meta = EXT_CLK_PIN;
    next_state.ext_sync = state.ext_meta;
    next_state.ext_prev = state.ext_sync;
    next_state.prescale = state.prescale + PRE_STEP;
    // Counting sequence on each tick
    ctl.down = state.down;
    if (tick) begin
      case (seq)
        SEQ_NORMAL: begin
          ctl.count = 1'b1;
          ovf_event = (value == MAX_VAL);
        end
        SEQ_CLEAR: begin
          ctl.clear = at_top;
          ctl.count = !at_top;
          ovf_event = (value == MAX_VAL);
        end
        SEQ_FAST: begin
          ctl.clear = at_top;
          ctl.count = !at_top;
          ovf_event = at_top;
        end
        SEQ_PHASE: begin
          ctl.count = 1'b1;
          if (!state.down && value >= top) begin
            ctl.down        = 1'b1;
            next_state.down = 1'b1;
          end else if (state.down && at_floor) begin
            ctl.down        = 1'b0;
            next_state.down = 1'b0;
            ovf_event       = 1'b1;
          end
        end
        default: begin
          ctl.count = 1'b0;
        end
      endcase
    end
    if (seq != SEQ_PHASE) begin
      next_state.down = 1'b0;
    end
    // CPU reads; data is registered for the next cycle
    if (IO_REQ.rd) begin
      case (IO_REQ.addr)
        ADDR_CTRL_FIRST:   next_state.rdata = state.ctrl_first;
        ADDR_CTRL_SECOND:  next_state.rdata = state.ctrl_second;
        ADDR_COUNT_LOWER: begin
          next_state.rdata   = value[7:0];
          next_state.staging = value[15:8];
        end
        ADDR_COUNT_UPPER:  next_state.rdata = state.staging;
        ADDR_MATCH_A_LOW:  next_state.rdata = state.match_a[7:0];
        ADDR_MATCH_A_HIGH: next_state.rdata = state.match_a[15:8];
        ADDR_MATCH_B_LOW:  next_state.rdata = state.match_b[7:0];
        ADDR_MATCH_B_HIGH: next_state.rdata = state.match_b[15:8];
        ADDR_CAPT_LOW: begin
          next_state.rdata   = state.capture[7:0];
          next_state.staging = state.capture[15:8];
        end
        ADDR_CAPT_HIGH:    next_state.rdata = state.staging;
        ADDR_FLAGS:        next_state.rdata = {7'h00, state.ovf};
        default:           next_state.rdata = RESET_BYTE;
      endcase
    end
    // CPU writes; high locations all land in the one staging register
    if (IO_REQ.wr) begin
      case (IO_REQ.addr)
        ADDR_CTRL_FIRST:  next_state.ctrl_first  = IO_REQ.wdata;
        ADDR_CTRL_SECOND: next_state.ctrl_second = IO_REQ.wdata;
        ADDR_COUNT_LOWER: begin
          ctl.load       = 1'b1;
          ctl.load_value = {state.staging, IO_REQ.wdata};
        end
        ADDR_COUNT_UPPER, ADDR_MATCH_A_HIGH, ADDR_MATCH_B_HIGH, ADDR_CAPT_HIGH: begin
          next_state.staging = IO_REQ.wdata;
        end
        ADDR_MATCH_A_LOW: next_state.match_a = {state.staging, IO_REQ.wdata};
        ADDR_MATCH_B_LOW: next_state.match_b = {state.staging, IO_REQ.wdata};
        ADDR_CAPT_LOW: begin
          if (capture_is_top(mode)) begin
            next_state.capture = {state.staging, IO_REQ.wdata};
          end
        end
        ADDR_FLAGS: begin
          if (IO_REQ.wdata[FLAG_OVF]) begin
            next_state.ovf = 1'b0;
          end
        end
        default: begin
          next_state.rdata = state.rdata;
        end
      endcase
    end
    // Overflow set wins over a clear in the same cycle; a discarded count sets no overflow
    if (ovf_event && !ctl.load) begin
      next_state.ovf = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign IO_RDATA      = state.rdata;
  assign COUNT_VALUE   = value;
  assign TIMER_TICK    = tick;
  assign TOP_REACHED   = at_top;
  assign FLOOR_REACHED = at_floor;
  assign OVERFLOW_FLAG = state.ovf;

  // Low-byte write commits staged high byte and written low byte
  property p_low_write_commits;
    @(posedge CLOCK) disable iff (RST)
      wr_count_low |=> COUNT_VALUE == {$past(state.staging), $past(IO_REQ.wdata)};
  endproperty
  a_low_write_commits: assert property (p_low_write_commits) else $error("low write did not commit");

  // Low-byte read stages the high half
  property p_low_read_stages;
    @(posedge CLOCK) disable iff (RST)
      (IO_REQ.rd && !IO_REQ.wr && IO_REQ.addr == ADDR_COUNT_LOWER)
        |=> state.staging == $past(COUNT_VALUE[15:8]) && IO_RDATA == $past(COUNT_VALUE[7:0]);
  endproperty
  a_low_read_stages: assert property (p_low_read_stages) else $error("low read did not stage high");

  // Match A reads leave staging alone
  property p_match_read_no_stage;
    @(posedge CLOCK) disable iff (RST)
      (IO_REQ.rd && !IO_REQ.wr && (IO_REQ.addr == ADDR_MATCH_A_LOW || IO_REQ.addr == ADDR_MATCH_A_HIGH))
        |=> $stable(state.staging);
  endproperty
  a_match_read_no_stage: assert property (p_match_read_no_stage) else $error("match read touched staging");

  // Upper counter read returns staging
  property p_upper_read_staging;
    @(posedge CLOCK) disable iff (RST)
      (IO_REQ.rd && IO_REQ.addr == ADDR_COUNT_UPPER) |=> IO_RDATA == $past(state.staging);
  endproperty
  a_upper_read_staging: assert property (p_upper_read_staging) else $error("upper read not from staging");

  // Upper counter write goes to staging, counter high half untouched without a tick
  property p_upper_write_staging;
    @(posedge CLOCK) disable iff (RST)
      (IO_REQ.wr && IO_REQ.addr == ADDR_COUNT_UPPER && !tick)
        |=> state.staging == $past(IO_REQ.wdata) && $stable(COUNT_VALUE);
  endproperty
  a_upper_write_staging: assert property (p_upper_write_staging) else $error("upper write reached counter");

  // Stopped clock holds the counter for several cycles
  property p_stopped_holds;
    @(posedge CLOCK) disable iff (RST)
      (csel == CS_STOP && !wr_count_low)[*2] |-> COUNT_VALUE == $past(COUNT_VALUE);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("counter moved while stopped");

  // Write beats a coincident count, and the discarded count sets no overflow
  property p_write_beats_tick;
    @(posedge CLOCK) disable iff (RST)
      (wr_count_low && tick)
        |=> COUNT_VALUE == {$past(state.staging), $past(IO_REQ.wdata)} && OVERFLOW_FLAG == $past(OVERFLOW_FLAG);
  endproperty
  a_write_beats_tick: assert property (p_write_beats_tick) else $error("count beat cpu write");

  // Normal mode tick increments by one
  property p_normal_increments;
    @(posedge CLOCK) disable iff (RST)
      (tick && seq == SEQ_NORMAL && !wr_count_low) |=> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001;
  endproperty
  a_normal_increments: assert property (p_normal_increments) else $error("normal tick did not increment");

  // Floor indication tracks zero
  property p_floor_indication;
    @(posedge CLOCK) disable iff (RST)
      FLOOR_REACHED == (COUNT_VALUE == FLOOR_VAL) && TOP_REACHED == (COUNT_VALUE == top);
  endproperty
  a_floor_indication: assert property (p_floor_indication) else $error("extreme indication wrong");

  // Fast mode at ceiling sets overflow and wraps to zero
  property p_fast_overflow;
    @(posedge CLOCK) disable iff (RST)
      (tick && seq == SEQ_FAST && TOP_REACHED && !wr_count_low) |=> OVERFLOW_FLAG && COUNT_VALUE == FLOOR_VAL;
  endproperty
  a_fast_overflow: assert property (p_fast_overflow) else $error("fast mode overflow missed");

  // Clear-on-match sequence returns to zero at the ceiling
  property p_clear_wraps;
    @(posedge CLOCK) disable iff (RST)
      (tick && seq == SEQ_CLEAR && TOP_REACHED && !wr_count_low) |=> COUNT_VALUE == FLOOR_VAL;
  endproperty
  a_clear_wraps: assert property (p_clear_wraps) else $error("clear mode did not wrap");

  // Writing one to the flag bit clears it when no overflow coincides
  property p_flag_clear;
    @(posedge CLOCK) disable iff (RST)
      (IO_REQ.wr && IO_REQ.addr == ADDR_FLAGS && IO_REQ.wdata[FLAG_OVF] && !ovf_event) |=> !OVERFLOW_FLAG;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("overflow flag not cleared");

  // Capture value is only writable while it sets the ceiling
  property p_capture_refused;
    @(posedge CLOCK) disable iff (RST)
      (IO_REQ.wr && IO_REQ.addr == ADDR_CAPT_LOW && !capture_is_top(mode)) |=> $stable(state.capture);
  endproperty
  a_capture_refused: assert property (p_capture_refused) else $error("capture written in wrong mode");

  // Phase-correct turn at zero sets overflow and counts up again
  property p_phase_reverses;
    @(posedge CLOCK) disable iff (RST)
      (tick && seq == SEQ_PHASE && state.down && FLOOR_REACHED && !wr_count_low) |=> OVERFLOW_FLAG && COUNT_VALUE == 16'h0001;
  endproperty
  a_phase_reverses: assert property (p_phase_reverses) else $error("phase turn at zero missed");

endmodule : tbac_timer
`default_nettype wire

/* File: dv/tbac_cpu_model.sv */
// CPU model: 8-bit bus master that makes byte and 16-bit accesses to the timer
`default_nettype none
module tbac_cpu_model
  import tbac_pkg::*;
(
  input  wire logic        clock,     // System clock
  output var tbac_io_req_t io_req,    // Byte request to the timer
  input  wire logic [7:0]  io_rdata   // Read data from the timer
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus is idle at time zero
  initial io_req = '0;

  // One byte access: the request is held up to the edge that takes it, and read data is sampled after that edge
  task automatic access(input logic [3:0] addr, input logic wr, input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge clock);
    io_req <= '{addr: addr, wr: wr, rd: ~wr, wdata: wdata};
    @(posedge clock);
    io_req.wr    <= 1'b0;
    io_req.rd    <= 1'b0;
    io_req.wdata <= ~wdata;  // A released data line does not keep its value
    #1;
    rdata = io_rdata;
  endtask : access

  // Single byte write
  task automatic wr8(input logic [3:0] addr, input logic [7:0] d);
    logic [7:0] unused;
    access(addr, 1'b1, d, unused);
  endtask : wr8

  // Single byte read
  task automatic rd8(input logic [3:0] addr, output logic [7:0] d);
    access(addr, 1'b0, 8'h00, d);
  endtask : rd8

  // 16-bit write as two byte writes, high location first; nothing else runs between them
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(4'(lo + 4'h1), v[15:8]);
    wr8(lo, v[7:0]);
  endtask : wr16

  // 16-bit read as two byte reads, low location first; the high byte comes back from staging
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo, v[7:0]);
    rd8(4'(lo + 4'h1), v[15:8]);
  endtask : rd16

endmodule : tbac_cpu_model
`default_nettype wire

/* File: dv/tbac_timer_tb.sv */
// Testbench: byte access, counting and clock select checks of the 16-bit timer
`default_nettype none
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module tbac_timer_tb
  import tbac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic         clock;
  logic         rst;
  logic         ext_pin;
  tbac_io_req_t io_req;
  logic [7:0]   io_rdata;
  logic [15:0]  count_value;
  logic         tick;
  logic         top_hit;
  logic         floor_hit;
  logic         ovf;
  int           fails = 0;
  int           n_checks = 0;
  int           cycles = 0;
  logic [15:0]  v16;
  logic [7:0]   v8;

  // Timer under test and the CPU on its byte bus
  tbac_timer DUT (.CLOCK(clock), .RST(rst), .IO_REQ(io_req), .IO_RDATA(io_rdata), .EXT_CLK_PIN(ext_pin),
    .COUNT_VALUE(count_value), .TIMER_TICK(tick), .TOP_REACHED(top_hit), .FLOOR_REACHED(floor_hit),
    .OVERFLOW_FLAG(ovf));
  tbac_cpu_model cpu (.clock(clock), .io_req(io_req), .io_rdata(io_rdata));

  // 20 MHz clock
  initial clock = 1'b0;
  always #25 clock = ~clock;

  // Cuts a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report;
    end
  end

  // Prints the counts and the verdict, then ends the run
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Lets n edges pass and settles after the last
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // Waits a bounded time for a counter value
  task automatic wait_cnt(input logic [15:0] v);
    int i;
    for (i = 0; i < 400 && count_value !== v; i++) step(1);
    `CHK(count_value, v)
  endtask : wait_cnt

  // Waveform mode over both control bytes, clock select in the second
  task automatic set_mode(input logic [3:0] m, input logic [2:0] cs);
    cpu.wr8(ADDR_CTRL_FIRST, {6'h00, m[1:0]});
    cpu.wr8(ADDR_CTRL_SECOND, {3'h0, m[3:2], cs});
  endtask : set_mode

  task automatic t_reset;
    `CHK(count_value, 16'h0000)
    `CHK(ovf, 1'b0)
    `CHK(floor_hit, 1'b1)
    step(4);
    `CHK(tick, 1'b0)
    cpu.rd16(ADDR_COUNT_LOWER, v16);
    `CHK(v16, 16'h0000)
  endtask : t_reset

  task automatic t_access;
    cpu.wr8(ADDR_COUNT_UPPER, 8'h01);
    `CHK(count_value, 16'h0000)
    cpu.wr8(ADDR_COUNT_LOWER, 8'hff);
    `CHK(count_value, 16'h01ff)
    cpu.rd16(ADDR_COUNT_LOWER, v16);
    `CHK(v16, 16'h01ff)
    cpu.wr8(ADDR_COUNT_UPPER, 8'h77);
    `CHK(count_value, 16'h01ff)
    cpu.rd8(ADDR_COUNT_UPPER, v8);
    `CHK(v8, 8'h77)
  endtask : t_access

  // One staged high byte serves three commits; match reads bypass staging
  task automatic t_share;
    cpu.wr8(ADDR_COUNT_UPPER, 8'hab);
    cpu.wr8(ADDR_MATCH_A_LOW, 8'h11);
    cpu.wr8(ADDR_MATCH_B_LOW, 8'h22);
    cpu.wr8(ADDR_COUNT_LOWER, 8'h33);
    `CHK(count_value, 16'hab33)
    cpu.rd8(ADDR_MATCH_A_HIGH, v8);
    `CHK(v8, 8'hab)
    cpu.rd8(ADDR_COUNT_LOWER, v8);
    `CHK(v8, 8'h33)
    cpu.rd8(ADDR_MATCH_B_HIGH, v8);
    `CHK(v8, 8'hab)
    cpu.rd8(ADDR_MATCH_A_LOW, v8);
    `CHK(v8, 8'h11)
    cpu.wr16(ADDR_COUNT_LOWER, 16'h0155);
    cpu.rd8(ADDR_COUNT_LOWER, v8);
    cpu.rd8(ADDR_MATCH_B_LOW, v8);
    `CHK(v8, 8'h22)
    cpu.rd8(ADDR_COUNT_UPPER, v8);
    `CHK(v8, 8'h01)
  endtask : t_share

  task automatic t_capture;
    set_mode(4'h0, CS_STOP);
    cpu.wr16(ADDR_CAPT_LOW, 16'h1234);
    cpu.rd16(ADDR_CAPT_LOW, v16);
    `CHK(v16, 16'h0000)
    set_mode(4'hc, CS_STOP);
    cpu.wr16(ADDR_CAPT_LOW, 16'h2345);
    cpu.rd16(ADDR_CAPT_LOW, v16);
    `CHK(v16, 16'h2345)
    cpu.wr8(4'hf, 8'h5a);
    cpu.rd8(4'hf, v8);
    `CHK(v8, 8'h00)
  endtask : t_capture

  // Fixed, match A, capture and full ceilings
  task automatic t_ceiling;
    logic [3:0]  md [6] = '{4'h5, 4'h6, 4'h7, 4'hf, 4'hc, 4'h0};
    logic [15:0] tp [6] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'hab11, 16'h2345, 16'hffff};
    int i;
    for (i = 0; i < 6; i++) begin
      set_mode(md[i], CS_STOP);
      cpu.wr16(ADDR_COUNT_LOWER, tp[i] - 16'h0001);
      `CHK(top_hit, 1'b0)
      cpu.wr16(ADDR_COUNT_LOWER, tp[i]);
      `CHK(top_hit, 1'b1)
      `CHK(floor_hit, 1'b0)
      cpu.wr16(ADDR_COUNT_LOWER, FLOOR_VAL);
      `CHK(floor_hit, 1'b1)
    end
  endtask : t_ceiling

  // Tick count of every clock select over a fixed window
  task automatic t_sources;
    logic [2:0] sel [6] = '{CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    int exp_n [6] = '{0, 1024, 128, 16, 4, 1};
    int k;
    int i;
    int j;
    for (i = 0; i < 6; i++) begin
      set_mode(4'h0, sel[i]);
      k = 0;
      for (j = 0; j < 1024; j++) begin
        step(1);
        k += int'(tick);
      end
      `CHK(k, exp_n[i])
    end
    for (i = 0; i < 2; i++) begin
      set_mode(4'h0, (i == 0) ? CS_EXT_RISE : CS_EXT_FALL);
      k = 0;
      for (j = 0; j < 64; j++) begin
        @(posedge clock);
        ext_pin <= j[3];
        #1;
        k += int'(tick);
      end
      `CHK(k, 4)
    end
    set_mode(4'h0, CS_STOP);
  endtask : t_sources

  task automatic t_count;
    logic [15:0] held;
    cpu.wr16(ADDR_COUNT_LOWER, 16'hfffe);
    cpu.wr8(ADDR_FLAGS, 8'h01);
    `CHK(ovf, 1'b0)
    set_mode(4'h0, CS_DIV1);
    wait_cnt(16'h0000);
    `CHK(ovf, 1'b1)
    step(1);
    `CHK(count_value, 16'h0001)
    set_mode(4'h0, CS_STOP);
    held = count_value;
    step(20);
    `CHK(count_value, held)
    cpu.wr8(ADDR_FLAGS, 8'h01);
    `CHK(ovf, 1'b0)
    set_mode(4'h1, CS_STOP);
    cpu.wr16(ADDR_COUNT_LOWER, 16'h00fe);
    set_mode(4'h1, CS_DIV1);
    wait_cnt(16'h00ff);
    step(1);
    `CHK(count_value, 16'h00fe)
    wait_cnt(16'h0000);
    step(1);
    `CHK(count_value, 16'h0001)
    `CHK(ovf, 1'b1)
  endtask : t_count

  // Counter write while ticking every cycle
  task automatic t_priority;
    set_mode(4'h0, CS_DIV1);
    cpu.wr16(ADDR_COUNT_LOWER, 16'h4000);
    `CHK(count_value, 16'h4000)
    step(1);
    `CHK(count_value, 16'h4001)
    set_mode(4'h0, CS_STOP);
  endtask : t_priority

  // Fast and clear-on-match sequences wrap at their ceilings
  task automatic t_wrap;
    set_mode(4'h5, CS_STOP);
    cpu.wr16(ADDR_COUNT_LOWER, 16'h00fd);
    cpu.wr8(ADDR_FLAGS, 8'h01);
    set_mode(4'h5, CS_DIV1);
    wait_cnt(16'h00ff);
    step(1);
    `CHK(count_value, 16'h0000)
    `CHK(ovf, 1'b1)
    cpu.rd8(ADDR_FLAGS, v8);
    `CHK(v8, 8'h01)
    set_mode(4'h4, CS_STOP);
    cpu.wr8(ADDR_FLAGS, 8'h01);
    cpu.wr16(ADDR_MATCH_A_LOW, 16'h0010);
    cpu.wr16(ADDR_COUNT_LOWER, 16'h000e);
    set_mode(4'h4, CS_DIV1);
    wait_cnt(16'h0010);
    step(1);
    `CHK(count_value, 16'h0000)
    `CHK(ovf, 1'b0)
    set_mode(4'h0, CS_STOP);
  endtask : t_wrap

  // Reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    ext_pin = 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1;
    t_reset;
    t_access;
    t_share;
    t_capture;
    t_ceiling;
    t_sources;
    t_count;
    t_priority;
    t_wrap;
    final_report;
  end

endmodule : tbac_timer_tb
`default_nettype wire
